// file: design/igm_pkg.sv
// Shared constants and carrier types for the gain/mode control slave
`default_nettype none
package igm_pkg;
    localparam logic [6:0] IGM_DEV_ADDR = 7'h6F;
    localparam int IGM_SEL_BIT = 7;
    localparam int IGM_MODE_PWR_BIT = 0;
    localparam int IGM_MODE_MUTE_BIT = 1;
    localparam int IGM_MODE_DIAG_BIT = 4;
    localparam logic [6:0] IGM_MODE_RESET = 7'h00;
    localparam logic [6:0] IGM_VOL_RESET = 7'h00;
    localparam logic [5:0] IGM_GAIN_MUTE_CODE = 6'h00;
    localparam logic [3:0] IGM_BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] IGM_GAIN_M90 = 8'hA6;

    typedef struct packed {
        logic power_enable_bit;
        logic mute_bit;
        logic factory_diag_bit;
        logic [5:0] gain_code;
    } igm_amp_ctrl_t;

    typedef enum logic [3:0] {
        IGM_IDLE = 4'b0001,
        IGM_ADDR = 4'b0010,
        IGM_DATA = 4'b0100,
        IGM_ACK = 4'b1000
    } igm_state_t;
endpackage
`default_nettype wire

// file: design/igm_regs.sv
// Two-wire write-only mode and volume register slave
`timescale 1ns/1ns
`default_nettype none
module igm_regs
    import igm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe_n,
    output igm_amp_ctrl_t o_amp,
    output logic signed [7:0] o_gain_db
);
    logic scl_s, sda_s, rstn_s, scl_d, sda_d;
    igm_state_t state, next_state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [6:0] mode_control, volume_control;
    logic addressed;
    logic ack_drive;

    // Pins cross domains, so two flops before any use
    igm_sync u_sync_scl (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_scl), .o_sync(scl_s));
    igm_sync u_sync_sda (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_sda), .o_sync(sda_s));
    igm_sync u_sync_rst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_reset_n), .o_sync(rstn_s));

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;
    wire [7:0] byte_in = {shreg[6:0], sda_s};
    wire byte_done = scl_rise && (bit_cnt == IGM_BITS_PER_BYTE - 4'h1);
    wire addr_hit = (byte_in[7:1] == IGM_DEV_ADDR) && !byte_in[0];
    wire is_vol = byte_in[IGM_SEL_BIT];
    wire in_shift = (state == IGM_ADDR) || (state == IGM_DATA);

    always_comb begin
        next_state = state;
        case (state)
            IGM_IDLE: next_state = state;
            IGM_ADDR: if (byte_done) next_state = addr_hit ? IGM_ACK : IGM_IDLE;
            IGM_DATA: if (byte_done) next_state = IGM_ACK;
            IGM_ACK: if (scl_fall && ack_drive) next_state = IGM_DATA;
            default: next_state = IGM_IDLE;
        endcase
        if (start_cond) next_state = IGM_ADDR;
        else if (stop_cond) next_state = IGM_IDLE;
        if (!rstn_s) next_state = IGM_IDLE;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= IGM_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            state <= next_state;
            if (start_cond || state == IGM_ACK) bit_cnt <= 4'h0;
            else if (in_shift && scl_rise) bit_cnt <= bit_cnt + 4'h1;
            if (in_shift && scl_rise) shreg <= byte_in;
        end
    end

    // Ack window: low from falling edge after 8th bit to next falling edge
    // Toggle per fall: first fall opens, second closes and leaves ack state
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ack_drive <= 1'b0;
            addressed <= 1'b0;
        end else if (!rstn_s || start_cond || stop_cond) begin
            ack_drive <= 1'b0;
            addressed <= 1'b0;
        end else if (state == IGM_ACK && scl_fall) begin
            ack_drive <= ~ack_drive;
            addressed <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            mode_control <= IGM_MODE_RESET;
            volume_control <= IGM_VOL_RESET;
        end else if (!rstn_s) begin
            mode_control <= IGM_MODE_RESET;
            volume_control <= IGM_VOL_RESET;
        end else if (state == IGM_DATA && byte_done && !start_cond && !stop_cond) begin
            if (is_vol) volume_control <= byte_in[6:0];
            else mode_control <= byte_in[6:0];
        end
    end

    wire [5:0] eff_code = mode_control[IGM_MODE_MUTE_BIT] ? IGM_GAIN_MUTE_CODE : volume_control[5:0];
    // Gain table; upper codes repeat low steps, then ramp
    wire signed [7:0] code_s = signed'({2'b00, eff_code});
    wire signed [7:0] ramp_lo = code_s * 8'sh02 - 8'sh16;
    wire signed [7:0] ramp_hi = code_s * 8'sh02 - 8'sh4E;
    logic signed [7:0] gain_lut;
    always_comb begin
        case (eff_code)
            6'h00, 6'h20: gain_lut = IGM_GAIN_M90;
            6'h01, 6'h21: gain_lut = 8'shE7;
            6'h02, 6'h22: gain_lut = 8'shEA;
            6'h03, 6'h23: gain_lut = 8'shED;
            6'h04, 6'h24: gain_lut = 8'shF0;
            6'h05, 6'h25: gain_lut = 8'shF3;
            6'h06, 6'h26: gain_lut = 8'shF6;
            6'h07, 6'h27: gain_lut = 8'shF8;
            6'h28: gain_lut = 8'shFA;
            6'h29: gain_lut = 8'shFC;
            6'h2A: gain_lut = 8'sh00;
            6'h2B: gain_lut = 8'sh04;
            6'h2C: gain_lut = 8'sh08;
            default: gain_lut = eff_code[5] ? ramp_hi : ramp_lo;
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_amp <= '0;
            o_gain_db <= IGM_GAIN_M90;
            o_sda <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else begin
            o_amp.power_enable_bit <= mode_control[IGM_MODE_PWR_BIT];
            o_amp.mute_bit <= mode_control[IGM_MODE_MUTE_BIT];
            o_amp.factory_diag_bit <= mode_control[IGM_MODE_DIAG_BIT];
            o_amp.gain_code <= volume_control[5:0];
            o_gain_db <= gain_lut;
            o_sda <= 1'b0;
            o_sda_oe_n <= ~ack_drive;
        end
    end

    AST_NO_READ_ACK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (state == IGM_ADDR && byte_done && byte_in[0]) |=> state == IGM_IDLE)
        else $error("read address accepted");
    AST_MUTE_GAIN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        mode_control[IGM_MODE_MUTE_BIT] |=> o_gain_db == IGM_GAIN_M90)
        else $error("mute gain wrong");
    AST_RESET_CLEARS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !rstn_s |=> volume_control == 7'h00 && mode_control == 7'h00)
        else $error("reset pin did not clear");
    AST_IDLE_HOLDS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (rstn_s && state == IGM_IDLE && !start_cond) |=> $stable(mode_control) && $stable(volume_control))
        else $error("write while idle");
    AST_MODE_LOAD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (rstn_s && state == IGM_DATA && byte_done && !byte_in[7] && !stop_cond) |=> mode_control == $past(byte_in[6:0]))
        else $error("mode load wrong");
    AST_VOL_LOAD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (rstn_s && state == IGM_DATA && byte_done && byte_in[7] && !stop_cond) |=> volume_control == $past(byte_in[6:0]))
        else $error("volume load wrong");
    AST_ACK_AFTER_BYTE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (rstn_s && state == IGM_DATA && byte_done && !start_cond && !stop_cond) |=> state == IGM_ACK)
        else $error("data byte not acked");
    AST_ACK_ON_MATCH: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(ack_drive) |-> $past(state) == IGM_ACK)
        else $error("ack outside window");
    AST_ADDR_MISS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (state == IGM_ADDR && byte_done && !addr_hit) |=> state == IGM_IDLE)
        else $error("foreign address accepted");
    AST_ACK_ENDS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (state == IGM_DATA) |-> !ack_drive)
        else $error("ack held into data");
    AST_CUT_BYTE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (rstn_s && (start_cond || stop_cond)) |=> $stable(mode_control) && $stable(volume_control))
        else $error("cut byte applied");
    AST_PWR_FOLLOWS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        ##1 o_amp.power_enable_bit == $past(mode_control[IGM_MODE_PWR_BIT]))
        else $error("power bit mismatch");
    COV_ADDR_ACK: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(ack_drive) && !addressed);
    COV_VOL_WRITE: cover property (@(posedge i_clk_sys) disable iff (i_rst) $changed(volume_control));
    COV_MUTE: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(mode_control[IGM_MODE_MUTE_BIT]));
    COV_CUT_BYTE: cover property (@(posedge i_clk_sys) disable iff (i_rst) state == IGM_DATA && stop_cond && bit_cnt > 4'h2);
endmodule
`default_nettype wire

// file: design/igm_sync.sv
// Two-flop synchroniser for one pin
`timescale 1ns/1ns
`default_nettype none
module igm_sync (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_pin,
    output logic o_sync
);
    logic meta;
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            meta <= 1'b1;
            o_sync <= 1'b1;
        end else begin
            meta <= i_pin;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

// file: tb/igm_master_bfm.sv
// Bus master model writing control bytes
`timescale 1ns/1ns
`default_nettype none
module igm_master_bfm (
    input wire logic i_clk_sys,
    output logic o_scl,
    output logic o_sda,
    output logic o_bit9
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        o_bit9 = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task automatic start();
        tick(2);
        o_sda = 1'b1;
        tick(8);
        o_scl = 1'b1;
        tick(8);
        o_sda = 1'b0;
        tick(8);
        o_scl = 1'b0;
    endtask
    task automatic stop();
        tick(2);
        o_sda = 1'b0;
        tick(8);
        o_scl = 1'b1;
        tick(8);
        o_sda = 1'b1;
        tick(8);
    endtask
    // MSB first; data moves late so it never looks like a start
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            tick(2);
            o_sda = b[i];
            tick(8);
            o_scl = 1'b1;
            tick(8);
            o_scl = 1'b0;
        end
        if (n == 8) begin
            tick(2);
            o_sda = 1'b1;
            tick(8);
            o_scl = 1'b1;
            o_bit9 = 1'b1;
            tick(8);
            o_scl = 1'b0;
            o_bit9 = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// file: tb/igm_regs_tb_top.sv
// Self-checking bench for the gain and mode slave
`timescale 1ns/1ns
`default_nettype none
module igm_regs_tb_top
    import igm_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, rst_pin_n = 1'b1;
    logic scl, m_sda, bit9, sda_oe_n, sda_o, sda_w;
    igm_amp_ctrl_t amp;
    logic signed [7:0] gain;
    logic [6:0] mode = 7'h00, vol = 7'h00;
    logic [17:0] q[$];
    int fails = 0, comparisons = 0, seed = 30;
    initial forever #10 clk = ~clk;
    // Pull-up: line low only if someone pulls
    assign sda_w = m_sda & (sda_oe_n | sda_o);
    igm_master_bfm i_igm_master_bfm (.i_clk_sys(clk), .o_scl(scl), .o_sda(m_sda), .o_bit9(bit9));
    igm_regs i_igm_regs (.i_clk_sys(clk), .i_rst(rst), .i_reset_n(rst_pin_n), .i_scl(scl), .i_sda(sda_w),
        .o_sda(sda_o), .o_sda_oe_n(sda_oe_n), .o_amp(amp), .o_gain_db(gain));
    function automatic logic [7:0] db(input logic [5:0] c);
        int t[8] = '{-25, -22, -19, -16, -13, -10, -8, -6};
        if (c == 6'h00) return 8'hA6;
        if (c < 6'h09) return 8'(t[c - 1]);
        if (c < 6'h20) return 8'(2 * c - 22);
        if (c < 6'h2A) return db(c - 6'h20);
        if (c < 6'h2D) return 8'(4 * (c - 6'h2A));
        return 8'(2 * c - 78);
    endfunction
    task automatic xfer(input logic [7:0] b, input logic dat, input logic ack);
        if (dat && ack && !b[7]) mode = b[6:0];
        if (dat && ack && b[7]) vol = b[6:0];
        q.push_back({ack, mode[0], mode[1], mode[4], vol[5:0], mode[1] ? 8'hA6 : db(vol[5:0])});
        i_igm_master_bfm.send(b, 8);
    endtask
    task automatic frame_end(input string name);
        i_igm_master_bfm.stop();
        $display("test %s done", name);
    endtask
    task automatic report_and_stop();
        if (q.size() != 0) fails++;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Checked at every ninth bus clock
    initial forever begin
        logic [17:0] e;
        @(posedge bit9);
        e = q.pop_front();
        comparisons++;
        if ({~sda_w, amp, gain} !== e) begin
            fails++;
            $display("unexpected ack_amp_gain expected %h seen %h", e, {~sda_w, amp, gain});
        end
    end
    // Hang guard
    initial begin
        #1000000;
        fails++;
        report_and_stop();
    end
    initial begin
        logic [7:0] b;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        i_igm_master_bfm.start();
        xfer(8'hDC, 1'b0, 1'b0);
        xfer(8'h81, 1'b1, 1'b0);
        i_igm_master_bfm.start();
        xfer(8'hDF, 1'b0, 1'b0);
        frame_end("address");
        i_igm_master_bfm.start();
        xfer(8'hDE, 1'b0, 1'b1);
        xfer(8'h01, 1'b1, 1'b1);
        frame_end("single");
        i_igm_master_bfm.start();
        xfer(8'hDE, 1'b0, 1'b1);
        for (int i = 0; i < 8; i++) begin
            b = (i < 4) ? 8'(60 + i) : 8'($random(seed) & 31);
            xfer(8'h80 | b, 1'b1, 1'b1);
        end
        xfer(8'h03, 1'b1, 1'b1);
        xfer(8'hC5, 1'b1, 1'b1);
        xfer(8'h00, 1'b1, 1'b1);
        xfer(8'h6D, 1'b1, 1'b1);
        frame_end("multi");
        i_igm_master_bfm.start();
        xfer(8'hDE, 1'b0, 1'b1);
        i_igm_master_bfm.send(8'h3F, 4);
        i_igm_master_bfm.stop();
        i_igm_master_bfm.start();
        xfer(8'hDE, 1'b0, 1'b1);
        frame_end("partial");
        rst_pin_n = 1'b0;
        repeat (4) @(negedge clk);
        mode = 7'h00;
        vol = 7'h00;
        i_igm_master_bfm.start();
        xfer(8'hDE, 1'b0, 1'b0);
        xfer(8'h81, 1'b1, 1'b0);
        i_igm_master_bfm.stop();
        rst_pin_n = 1'b1;
        repeat (4) @(negedge clk);
        i_igm_master_bfm.start();
        xfer(8'hDE, 1'b0, 1'b1);
        frame_end("reset pin");
        report_and_stop();
    end
endmodule
`default_nettype wire
